// ---- pkg/codec_clk_pkg.sv ----
`default_nettype none
package codec_clk_pkg;
   localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'h0000;
   localparam logic [15:0] ADDR_PLL_PARAM_FIRST = 16'h0001;
   localparam logic [15:0] ADDR_SYNTH_PARAM_TOP = 16'h0005;
   localparam logic [15:0] ADDR_PLL_STATUS = 16'h0006;
   localparam logic [15:0] ADDR_CORE_RUN_CONTROL = 16'h0009;
   localparam logic [15:0] ADDR_OPEN_LAST = 16'h0006;

   localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
   localparam logic [7:0] RST_PLL_PARAM = 8'h00;
   localparam logic [7:0] RST_CORE_RUN_CONTROL = 8'h00;
   localparam logic [7:0] MASK_CLOCK_CONTROL = 8'h9F;
   localparam logic [7:0] MASK_SYNTH_PARAM_TOP = 8'h7F;
   localparam logic [7:0] MASK_CORE_RUN_CONTROL = 8'h31;

   localparam int CORE_RUN_BIT = 0;
   localparam int DAC_ROUTE_A_BIT = 4;
   localparam int DAC_ROUTE_B_BIT = 5;
   localparam int PARAM_COUNT = 5;

   localparam int CLK_KHZ = 125000;
   localparam int POR_TIME_MS = 12;
   localparam int POR_CYCLES = POR_TIME_MS * CLK_KHZ;
   localparam int LOCK_EDGES = 1024;

   typedef struct packed {
      logic pllEnable;
      logic [1:0] spare;
      logic xtalSelect;
      logic clockOriginSelect;
      logic coreClockHalveSelect;
      logic masterClockHalveSelect;
      logic coreClockGateOn;
   } clkCtrl_type;

   typedef struct packed {
      logic [15:0] den;
      logic [15:0] num;
      logic [3:0] intFactor;
      logic [1:0] preDiv;
      logic fracMode;
   } pllCfg_type;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } regReq_type;
endpackage : codec_clk_pkg
`default_nettype wire

// ---- rtl/codec_pll_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_pll_model #(
   parameter int LockEdges = codec_clk_pkg::LOCK_EDGES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic refEdge,
   input wire logic enable,
   input wire codec_clk_pkg::pllCfg_type cfg,
   output logic locked,
   output logic pllTick
);
   logic [1:0] preCnt_r, preCnt_nxt;
   logic [23:0] acc_r, acc_nxt;
   logic [15:0] lockCnt_r, lockCnt_nxt;
   logic locked_r, locked_nxt;
   logic tick_r, tick_nxt;
   codec_clk_pkg::pllCfg_type cfgSeen_r;
   logic divEdge;
   logic useFrac;
   logic [23:0] step;
   logic [23:0] thr;

   always_comb begin
      divEdge = refEdge && (preCnt_r == cfg.preDiv);
      preCnt_nxt = preCnt_r;
      if (!enable) begin
         preCnt_nxt = 2'h0;
      end else if (refEdge) begin
         preCnt_nxt = divEdge ? 2'h0 : preCnt_r + 2'h1;
      end
      // zero denominator falls back to integer so the accumulator cannot stall
      useFrac = cfg.fracMode && (cfg.den != 16'h0000);
      if (useFrac) begin
         step = 24'(cfg.intFactor) * 24'(cfg.den) + 24'(cfg.num);
         thr = {7'h00, cfg.den, 1'b0};
      end else begin
         step = 24'(cfg.intFactor);
         thr = 24'h000002;
      end
      tick_nxt = enable && (acc_r >= thr);
      acc_nxt = acc_r + (divEdge ? step : 24'h000000) - (tick_nxt ? thr : 24'h000000);
      if (!enable) begin
         acc_nxt = 24'h000000;
      end
      lockCnt_nxt = lockCnt_r;
      locked_nxt = locked_r;
      if (!enable || (cfg != cfgSeen_r)) begin
         lockCnt_nxt = 16'h0000;
         locked_nxt = 1'b0;
      end else if (divEdge && !locked_r) begin
         lockCnt_nxt = lockCnt_r + 16'h0001;
         locked_nxt = (lockCnt_r == 16'(LockEdges - 1));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         preCnt_r <= 2'h0;
         acc_r <= 24'h000000;
         lockCnt_r <= 16'h0000;
         locked_r <= 1'b0;
         tick_r <= 1'b0;
         cfgSeen_r <= '0;
      end else begin
         preCnt_r <= preCnt_nxt;
         acc_r <= acc_nxt;
         lockCnt_r <= lockCnt_nxt;
         locked_r <= locked_nxt;
         tick_r <= tick_nxt;
         cfgSeen_r <= cfg;
      end
   end

   assign locked = locked_r;
   assign pllTick = tick_r;
endmodule : codec_pll_model
`default_nettype wire

// ---- rtl/codec_clock_pll_init.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_clock_pll_init #(
   parameter int PowerUpCycles = codec_clk_pkg::POR_CYCLES,
   parameter int LockEdges = codec_clk_pkg::LOCK_EDGES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic referenceClockPin,
   input wire logic xtalClockPin,
   input wire codec_clk_pkg::regReq_type regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   output logic regDenied,
   output logic internalResetActive,
   output logic xtalOscEnable,
   output logic masterClockTick,
   output logic coreClockTick,
   output logic pllLocked,
   output logic coreRun,
   output logic [1:0] dacRouteSelect
);
   function automatic logic halve(input logic divByOne, input logic phase);
      halve = divByOne | phase;
   endfunction : halve

   // synchronisers and edge detect for the clock pins
   logic [1:0] refSync_r, refSync_nxt;
   logic [1:0] xtalSync_r, xtalSync_nxt;
   logic refPrev_r, refPrev_nxt;
   logic xtalPrev_r, xtalPrev_nxt;

   // power-up reset timer
   logic [31:0] porCount_r, porCount_nxt;
   logic porActive_r, porActive_nxt;

   // register file
   codec_clk_pkg::clkCtrl_type clkCtrl_r, clkCtrl_nxt;
   logic [codec_clk_pkg::PARAM_COUNT-1:0][7:0] pllParam_r, pllParam_nxt;
   logic [7:0] coreRunCtrl_r, coreRunCtrl_nxt;
   logic [7:0] rdData_r, rdData_nxt;
   logic rdValid_r, rdValid_nxt;
   logic denied_r, denied_nxt;

   // clock dividers
   logic phase_r, phase_nxt;
   logic masterTick_r, masterTick_nxt;
   logic coreTick_r, coreTick_nxt;

   logic refEdge;
   logic selEdge;
   logic srcTick;
   logic pllTick;
   logic lockDet;
   logic accessOpen;
   logic inOpenRange;
   logic [15:0] paramIdx;
   codec_clk_pkg::pllCfg_type pllCfg;

   always_comb begin
      refSync_nxt = {refSync_r[0], referenceClockPin};
      xtalSync_nxt = {xtalSync_r[0], xtalClockPin};
      refPrev_nxt = refSync_r[1];
      xtalPrev_nxt = xtalSync_r[1];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         refSync_r <= 2'h0;
         xtalSync_r <= 2'h0;
         refPrev_r <= 1'b0;
         xtalPrev_r <= 1'b0;
      end else begin
         refSync_r <= refSync_nxt;
         xtalSync_r <= xtalSync_nxt;
         refPrev_r <= refPrev_nxt;
         xtalPrev_r <= xtalPrev_nxt;
      end
   end

   always_comb begin
      porCount_nxt = porCount_r;
      porActive_nxt = porActive_r;
      if (porActive_r) begin
         porCount_nxt = porCount_r + 32'h00000001;
         porActive_nxt = (porCount_r != 32'(PowerUpCycles - 1));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         porCount_r <= 32'h00000000;
         porActive_r <= 1'b1;
      end else begin
         porCount_r <= porCount_nxt;
         porActive_r <= porActive_nxt;
      end
   end

   // crystal path has no edges until the oscillator is running
   assign refEdge = refSync_r[1] & ~refPrev_r;
   assign selEdge = clkCtrl_r.xtalSelect ? (xtalSync_r[1] & ~xtalPrev_r) : refEdge;

   // one driver for the whole config: den hi/lo, num hi/lo, then top byte fields
   assign pllCfg = {pllParam_r[0], pllParam_r[1], pllParam_r[2], pllParam_r[3],
                    pllParam_r[4][6:0]};

   codec_pll_model #(
      .LockEdges(LockEdges)
   ) pll (
      .ref_clk(ref_clk),
      .rst(rst),
      .refEdge(selEdge),
      .enable(clkCtrl_r.pllEnable),
      .cfg(pllCfg),
      .locked(lockDet),
      .pllTick(pllTick)
   );

   assign accessOpen = clkCtrl_r.coreClockGateOn & lockDet;
   assign inOpenRange = regReq.addr <= codec_clk_pkg::ADDR_OPEN_LAST;
   assign paramIdx = regReq.addr - codec_clk_pkg::ADDR_PLL_PARAM_FIRST;

   always_comb begin
      clkCtrl_nxt = clkCtrl_r;
      pllParam_nxt = pllParam_r;
      coreRunCtrl_nxt = coreRunCtrl_r;
      rdData_nxt = 8'h00;
      rdValid_nxt = 1'b0;
      denied_nxt = 1'b0;
      if (porActive_r) begin
         // port is dead while the internal reset holds
         clkCtrl_nxt = codec_clk_pkg::RST_CLOCK_CONTROL;
         pllParam_nxt = {codec_clk_pkg::PARAM_COUNT{codec_clk_pkg::RST_PLL_PARAM}};
         coreRunCtrl_nxt = codec_clk_pkg::RST_CORE_RUN_CONTROL;
      end else if (regReq.wr || regReq.rd) begin
         if (!inOpenRange && !accessOpen) begin
            denied_nxt = 1'b1;
         end else begin
            rdValid_nxt = regReq.rd;
            case (regReq.addr)
               codec_clk_pkg::ADDR_CLOCK_CONTROL: begin
                  rdData_nxt = clkCtrl_r;
                  if (regReq.wr) begin
                     // source select may change at any time
                     clkCtrl_nxt = regReq.wdata & codec_clk_pkg::MASK_CLOCK_CONTROL;
                  end
               end
               codec_clk_pkg::ADDR_PLL_STATUS: begin
                  rdData_nxt = {7'h00, lockDet};
               end
               codec_clk_pkg::ADDR_CORE_RUN_CONTROL: begin
                  rdData_nxt = coreRunCtrl_r;
                  if (regReq.wr) begin
                     coreRunCtrl_nxt = regReq.wdata & codec_clk_pkg::MASK_CORE_RUN_CONTROL;
                  end
               end
               default: begin
                  if (regReq.addr >= codec_clk_pkg::ADDR_PLL_PARAM_FIRST &&
                      regReq.addr <= codec_clk_pkg::ADDR_SYNTH_PARAM_TOP) begin
                     rdData_nxt = pllParam_r[paramIdx[2:0]];
                     if (regReq.wr) begin
                        pllParam_nxt[paramIdx[2:0]] = regReq.wdata;
                        if (regReq.addr == codec_clk_pkg::ADDR_SYNTH_PARAM_TOP) begin
                           pllParam_nxt[paramIdx[2:0]] =
                              regReq.wdata & codec_clk_pkg::MASK_SYNTH_PARAM_TOP;
                        end
                     end
                  end
               end
            endcase
            // write-only cycles keep the read bus at zero
            if (!regReq.rd) begin
               rdData_nxt = 8'h00;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clkCtrl_r <= codec_clk_pkg::RST_CLOCK_CONTROL;
         pllParam_r <= {codec_clk_pkg::PARAM_COUNT{codec_clk_pkg::RST_PLL_PARAM}};
         coreRunCtrl_r <= codec_clk_pkg::RST_CORE_RUN_CONTROL;
         rdData_r <= 8'h00;
         rdValid_r <= 1'b0;
         denied_r <= 1'b0;
      end else begin
         clkCtrl_r <= clkCtrl_nxt;
         pllParam_r <= pllParam_nxt;
         coreRunCtrl_r <= coreRunCtrl_nxt;
         rdData_r <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
         denied_r <= denied_nxt;
      end
   end

   // bypass takes the selected pin edges (reference or crystal) directly; no lock check on purpose
   assign srcTick = clkCtrl_r.clockOriginSelect ? pllTick : selEdge;

   always_comb begin
      phase_nxt = srcTick ? ~phase_r : phase_r;
      masterTick_nxt = clkCtrl_r.coreClockGateOn & srcTick &
                       halve(clkCtrl_r.masterClockHalveSelect, phase_r);
      coreTick_nxt = clkCtrl_r.coreClockGateOn & srcTick &
                     halve(clkCtrl_r.coreClockHalveSelect, phase_r);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase_r <= 1'b0;
         masterTick_r <= 1'b0;
         coreTick_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         masterTick_r <= masterTick_nxt;
         coreTick_r <= coreTick_nxt;
      end
   end

   assign regRdData = rdData_r;
   assign regRdValid = rdValid_r;
   assign regDenied = denied_r;
   assign internalResetActive = porActive_r;
   assign xtalOscEnable = clkCtrl_r.coreClockGateOn & clkCtrl_r.xtalSelect;
   assign masterClockTick = masterTick_r;
   assign coreClockTick = coreTick_r;
   assign pllLocked = lockDet;
   assign coreRun = coreRunCtrl_r[codec_clk_pkg::CORE_RUN_BIT];
   assign dacRouteSelect = {coreRunCtrl_r[codec_clk_pkg::DAC_ROUTE_B_BIT],
                            coreRunCtrl_r[codec_clk_pkg::DAC_ROUTE_A_BIT]};
endmodule : codec_clock_pll_init
`default_nettype wire

// ---- dv/codec_clock_pll_init_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_clock_pll_init_properties #(
   parameter int PowerUpCycles = 20
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire codec_clk_pkg::regReq_type regReq,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regDenied,
   input wire logic internalResetActive,
   input wire logic xtalOscEnable,
   input wire logic masterClockTick,
   input wire logic coreClockTick,
   input wire logic pllLocked,
   input wire logic coreRun,
   input wire logic [1:0] dacRouteSelect
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [31:0] porCnt_r;
   logic [31:0] porCnt_nxt;
   logic take;
   assign take = (regReq.wr | regReq.rd) & !internalResetActive;
   always_comb porCnt_nxt = internalResetActive ? porCnt_r + 32'h1 : porCnt_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) porCnt_r <= 32'h0;
      else porCnt_r <= porCnt_nxt;
   end
   sequence closedReq; take && regReq.addr > 16'h0006 && !pllLocked; endsequence
   sequence ctrlWr; take && regReq.wr && regReq.addr == 16'h0000; endsequence
   AST_POR_LEN: assert property ($fell(internalResetActive) |-> porCnt_r == PowerUpCycles)
      else $error("power-up reset length wrong");
   AST_QUIET: assert property (internalResetActive |=> !regRdValid && !regDenied
      && !coreClockTick && !masterClockTick) else $error("activity during power-up reset");
   AST_DENY: assert property (closedReq |=> regDenied && !regRdValid)
      else $error("closed register not refused");
   AST_OPEN: assert property (take && regReq.addr <= 16'h0006 |=> !regDenied)
      else $error("open register refused");
   AST_RDV: assert property (take && regReq.rd && regReq.addr <= 16'h0006 |=> regRdValid)
      else $error("read not answered");
   AST_IDLE_DATA: assert property (!regRdValid |-> regRdData == 8'h00)
      else $error("read data outside valid");
   AST_LOCK_DROP: assert property (ctrlWr and !regReq.wdata[7] |-> ##2 !pllLocked)
      else $error("lock kept after pll disable");
   AST_TICK_STOP: assert property (ctrlWr and !regReq.wdata[0]
      |-> ##3 (!coreClockTick && !masterClockTick)[*3]) else $error("ticks while gated");
   AST_XTAL: assert property ($changed(xtalOscEnable) |-> $past(take && regReq.wr
      && regReq.addr == 16'h0000)) else $error("oscillator enable changed alone");
   AST_RUN: assert property ($changed({coreRun, dacRouteSelect}) |-> $past(take
      && regReq.wr && regReq.addr == 16'h0009)) else $error("core run changed alone");
endmodule : codec_clock_pll_init_properties
bind codec_clock_pll_init codec_clock_pll_init_properties #(.PowerUpCycles(PowerUpCycles))
   u_props (.ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
   .regRdValid(regRdValid), .regDenied(regDenied), .internalResetActive(internalResetActive),
   .xtalOscEnable(xtalOscEnable), .masterClockTick(masterClockTick),
   .coreClockTick(coreClockTick), .pllLocked(pllLocked), .coreRun(coreRun),
   .dacRouteSelect(dacRouteSelect));
`default_nettype wire

// ---- dv/codec_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_host_model (
   input wire logic ref_clk,
   output var codec_clk_pkg::regReq_type regReq,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regDenied
);
   initial begin
      regReq = '0;
   end
   // request lives one edge; released lines show inverted junk, not the old value
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] q, output logic ok, output logic den);
      @(posedge ref_clk);
      regReq <= '{addr: a, wr: wr, rd: !wr, wdata: d};
      @(posedge ref_clk);
      regReq <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
      @(posedge ref_clk);
      q = regRdData;
      ok = regRdValid;
      den = regDenied;
   endtask : access
endmodule : codec_host_model
`default_nettype wire

// ---- dv/codec_clock_pll_init_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_clock_pll_init_tb;
   localparam int PorCycles = 20;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic referenceClockPin = 1'b0;
   logic xtalClockPin = 1'b1;
   logic tog = 1'b0;
   codec_clk_pkg::regReq_type regReq;
   logic [7:0] regRdData;
   logic [7:0] q;
   logic regRdValid, regDenied, internalResetActive, xtalOscEnable, ok, den;
   logic masterClockTick, coreClockTick, pllLocked, coreRun;
   logic [1:0] dacRouteSelect;
   int error_cnt = 0;
   int num_checks = 0;
   codec_clock_pll_init #(.PowerUpCycles(PorCycles), .LockEdges(4)) u_dut (.ref_clk(ref_clk),
      .rst(rst), .referenceClockPin(referenceClockPin), .xtalClockPin(xtalClockPin),
      .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .regDenied(regDenied),
      .internalResetActive(internalResetActive), .xtalOscEnable(xtalOscEnable),
      .masterClockTick(masterClockTick), .coreClockTick(coreClockTick),
      .pllLocked(pllLocked), .coreRun(coreRun), .dacRouteSelect(dacRouteSelect));
   codec_host_model u_host (.ref_clk(ref_clk), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .regDenied(regDenied));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // reference at a quarter of ref_clk: 100 rising edges per 400 cycles
   always @(posedge ref_clk) begin
      tog <= ~tog;
      if (tog) referenceClockPin <= ~referenceClockPin;
      // crystal only oscillates while the device enables it
      if (xtalOscEnable) xtalClockPin <= ~xtalClockPin;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      u_host.access(wr, a, d, q, ok, den);
   endtask : acc
   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk({den, ok, q}, {2'b01, exp}, "read");
   endtask : rdchk
   // tick counts allow a few edges of phase slop at the window ends
   task automatic measure(input int exp);
      int m = 0;
      int c = 0;
      repeat (8) @(posedge ref_clk);
      repeat (400) begin
         @(posedge ref_clk);
         m += masterClockTick;
         c += coreClockTick;
      end
      chk(m >= exp - 3 && m <= exp + 3, 1, "master rate");
      chk(c >= exp - 3 && c <= exp + 3, 1, "core rate");
   endtask : measure
   task automatic t_reset;
      int n = 0;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      while (internalResetActive === 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(n, PorCycles, "power-up length");
      chk({xtalOscEnable, coreClockTick, masterClockTick, pllLocked}, 0, "idle");
   endtask : t_reset
   task automatic t_basic;
      t_reset();
      rdchk(16'h0000, 8'h00);
      rdchk(16'h0006, 8'h00);
      acc(1'b1, 16'h0009, 8'h31);
      chk({den, coreRun}, 2'b10, "closed write");
      acc(1'b1, 16'h0000, 8'h01);
      measure(50);
   endtask : t_basic
   task automatic t_pll(input logic [7:0] cfg5, input int exp);
      int n = 0;
      t_reset();
      acc(1'b1, 16'h0000, 8'h00);
      acc(1'b1, 16'h0002, 8'h02);
      acc(1'b1, 16'h0004, 8'h01);
      acc(1'b1, 16'h0005, cfg5);
      rdchk(16'h0006, 8'h00);
      acc(1'b1, 16'h0000, 8'h88);
      q = 8'h00;
      while (q[0] !== 1'b1 && n < 50) begin
         acc(1'b0, 16'h0006, 8'h00);
         n++;
      end
      chk(q, 8'h01, "lock");
      acc(1'b0, 16'h0009, 8'h00);
      chk(den, 1, "core still off");
      acc(1'b1, 16'h0000, 8'h89);
      measure(exp);
   endtask : t_pll
   task automatic t_open;
      rdchk(16'h0007, 8'h00);
      acc(1'b1, 16'h0009, 8'h31);
      chk({coreRun, dacRouteSelect}, 3'b111, "run bits");
      rdchk(16'h0009, 8'h31);
      acc(1'b1, 16'h0000, 8'h99);
      chk(xtalOscEnable, 1, "osc on");
      acc(1'b1, 16'h0000, 8'h01);
      chk(xtalOscEnable, 0, "osc off");
      measure(50);
      rdchk(16'h0006, 8'h00);
      acc(1'b0, 16'h0009, 8'h00);
      chk(den, 1, "closed again");
      acc(1'b1, 16'h0000, 8'h10);
      chk(xtalOscEnable, 0, "osc gated");
      measure(0);
   endtask : t_open
   task automatic stop_test;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      t_basic();
      t_pll(8'h20, 100);
      t_pll(8'h22, 50);
      t_pll(8'h19, 88);
      t_open();
      t_reset();
      stop_test();
   end
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end
endmodule : codec_clock_pll_init_tb
`default_nettype wire
